// ---- dv/ppc_pin_model.sv ----
// Pin and load model facing one port slice: pad levels and short loads.
// Assumes pad controls arrive combinationally on the slice's own clock.
`timescale 1ns/1ps
`default_nettype none

module ppc_pin_model import ppc_pkg::*; (
  // Pad side
  input  wire ppc_pad_t   pad_in,
  // Bench controls
  input  wire logic [7:0] ext_lvl_in,
  input  wire logic [7:0] short_in,
  // Sensed levels
  output logic      [7:0] pin_out,
  output logic      [7:0] oc_out
);
  // Driver wins, then pull device, then the outside world
  assign pin_out = (pad_in.oe & pad_in.out)
                 | (~pad_in.oe & pad_in.pull_en & pad_in.pull_up)
                 | (~pad_in.oe & ~pad_in.pull_en & ext_lvl_in);
  // Comparator trips only while a driver feeds the short
  assign oc_out  = short_in & pad_in.oe;
endmodule

`default_nettype wire

// ---- dv/ppc_port_tb.sv ----
// Self-checking bench for the port slice: bus, pads, over-current, HIGH_VOLTAGE_INPUT.
// Assumes the slice answers on Wishbone one cycle after taking a request.
`timescale 1ns/1ps
`default_nettype none

module ppc_port_tb import ppc_pkg::*; ();
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, stop = 1'b0, high_voltage_input = 1'b0;
  logic [7:0]  adr = 8'h00, ext = 8'h00, shrt = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  ppc_periph_t pull_enable = '0;
  ppc_pad_t    pad;
  logic [31:0] rdat;
  logic        ack, ocirq, hbuf, hirq, wake;
  logic [7:0]  wakes = 8'h00;
  logic [7:0]  pin, oc, mon;
  int          failures = 0;
  int          checked = 0;

  // Clock, 5 ns period
  always #2.5 mclk_in = ~mclk_in;

  // Wake pulses last one cycle, so count them rather than poll
  always @(posedge mclk_in) begin
    if (wake === 1'b1) begin
      wakes <= wakes + 8'h01;
    end
  end

  ppc_port ppc_port_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .periph_in(pull_enable), .pin_in(pin),
    .oc_detect_in(oc), .stop_mode_in(stop), .pad_out(pad),
    .oc_monitor_on_out(mon), .oc_irq_out(ocirq), .hvi_in(high_voltage_input),
    .hvi_buf_en_out(hbuf), .hvi_irq_out(hirq), .hvi_wake_out(wake));
  ppc_pin_model ppc_pin_model_inst (
    .pad_in(pad), .ext_lvl_in(ext), .short_in(shrt), .pin_out(pin),
    .oc_out(oc));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  // One classic cycle; waits for ack, released after it or after a 16-cycle timeout
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat[7:0];
    if (n >= 16) begin
      failures++;
      $display("MISMATCH %0t bus timeout", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string m);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e, m);
  endtask

  task automatic t_data();
    rd(PPC_OFS_DATA, PPC_RST_BYTE, "data reset");
    @(negedge mclk_in);
    chk(pad.oe, 8'h00, "oe reset");
    wr(PPC_OFS_DIR, 8'hff);
    wr(PPC_OFS_DATA, 8'ha5);
    rd(PPC_OFS_DATA, 8'ha5, "data readback");
    @(negedge mclk_in);
    chk(pad.out, 8'ha5, "pad out");
    @(posedge mclk_in);
    ext <= 8'h3c;
    wr(PPC_OFS_DIR, 8'h0f);
    repeat (6) @(posedge mclk_in);
    rd(PPC_OFS_DATA, 8'h35, "mixed source");
    rd(PPC_OFS_LEVEL, 8'h35, "level");
    rd(8'h3c, 8'h00, "unmapped");
    wr(PPC_OFS_PULLEN, 8'hf0);
    wr(PPC_OFS_PULLPO, 8'hc0);
    ext <= 8'hc0;
    repeat (6) @(posedge mclk_in);
    rd(PPC_OFS_LEVEL, 8'h35, "pull level");
    $display("t_data done");
  endtask

  task automatic t_periph();
    wr(PPC_OFS_DIR, 8'h00);
    wr(PPC_OFS_PULLEN, 8'hff);
    pull_enable.tim_en <= 8'h01;
    pull_enable.sci_en <= 8'h02;
    pull_enable.sci_val <= 8'h02;
    pull_enable.dac_en <= 8'h04;
    pull_enable.spi_en <= 8'h08;
    @(negedge mclk_in);
    chk(pad.oe, 8'h03, "forced outputs");
    chk(pad.pull_en, 8'hf8, "pulls off");
    chk(pad.out & 8'h03, 8'h02, "periph values");
    @(posedge mclk_in);
    pull_enable.spi_oe <= 8'h08;
    pull_enable.dac_en <= 8'h05;
    @(negedge mclk_in);
    chk(pad.oe, 8'h0a, "spi out, dac first");
    chk(pad.pull_en, 8'hf0, "spi pull off");
    // Open-drain: sci high released, spi input loses its pulldown
    @(posedge mclk_in);
    pull_enable.spi_oe <= 8'h00;
    wr(PPC_OFS_WOR, 8'h0a);
    wr(PPC_OFS_PULLPO, 8'h08);
    @(negedge mclk_in);
    chk(pad.oe, 8'h00, "open-drain high released");
    chk(pad.pull_en, 8'hf0, "open-drain pulldown off");
    @(posedge mclk_in);
    pull_enable <= '0;
    wr(PPC_OFS_WOR, 8'h00);
    wr(PPC_OFS_PULLEN, 8'h00);
    $display("t_periph done");
  endtask

  task automatic t_oc();
    wr(PPC_OFS_DIR, 8'hff);
    wr(PPC_OFS_DATA, 8'ha4);
    wr(PPC_OFS_OCMON, 8'h05);
    wr(PPC_OFS_OCIE, 8'h04);
    chk(mon, 8'h05, "monitor power");
    shrt <= 8'h05;
    repeat (10) @(posedge mclk_in);
    rd(PPC_OFS_OCFLAG, 8'h05, "flags set");
    @(negedge mclk_in);
    chk({4'h0, pad.oe[2], pad.out[2], pad.oe[0], pad.out[0]}, 8'h09,
        "forced levels");
    chk({7'h0, ocirq}, 8'h01, "irq on");
    wr(PPC_OFS_OCIE, 8'h00);
    chk({7'h0, ocirq}, 8'h00, "irq masked");
    shrt <= 8'h00;
    repeat (8) @(posedge mclk_in);
    wr(PPC_OFS_OCFLAG, 8'h00);
    rd(PPC_OFS_OCFLAG, 8'h05, "zero keeps");
    wr(PPC_OFS_OCFLAG, 8'h04);
    rd(PPC_OFS_OCFLAG, 8'h01, "one clears");
    @(negedge mclk_in);
    chk({7'h0, pad.out[2]}, 8'h01, "driver back");
    wr(PPC_OFS_OCFLAG, 8'h01);
    stop <= 1'b1;
    shrt <= 8'h04;
    @(negedge mclk_in);
    chk(mon, 8'h00, "stop powers down");
    repeat (10) @(posedge mclk_in);
    rd(PPC_OFS_OCFLAG, 8'h00, "stop no flag");
    wr(PPC_OFS_RDRV, 8'h04);
    stop <= 1'b0;
    repeat (10) @(posedge mclk_in);
    rd(PPC_OFS_OCFLAG, 8'h00, "reduced drive");
    chk(pad.full_drv, 8'hfb, "drive field");
    wr(PPC_OFS_DATA, 8'ha0);
    wr(PPC_OFS_RDRV, 8'h00);
    repeat (10) @(posedge mclk_in);
    rd(PPC_OFS_OCFLAG, 8'h00, "sinking supply");
    shrt <= 8'h00;
    $display("t_oc done");
  endtask

  task automatic t_hvi();
    wr(PPC_OFS_HVI, 8'h0c);
    chk({7'h0, hbuf}, 8'h01, "digital buffer");
    high_voltage_input <= 1'b1;
    repeat (8) @(posedge mclk_in);
    @(negedge mclk_in);
    chk({7'h0, hirq}, 8'h01, "pin irq");
    wr(PPC_OFS_HVI, 8'h1d);
    chk({7'h0, hbuf}, 8'h00, "analog off");
    wr(PPC_OFS_HVI, 8'h0f);
    chk({7'h0, hbuf}, 8'h01, "override");
    high_voltage_input <= 1'b0;
    repeat (8) @(posedge mclk_in);
    high_voltage_input <= 1'b1;
    repeat (8) @(posedge mclk_in);
    chk({7'h0, hirq}, 8'h00, "analog no irq");
    high_voltage_input <= 1'b0;
    stop <= 1'b1;
    repeat (8) @(posedge mclk_in);
    high_voltage_input <= 1'b1;
    repeat (8) @(posedge mclk_in);
    chk(wakes, 8'h01, "analog wake");
    stop <= 1'b0;
    $display("t_hvi done");
  endtask

  // Main sequence after a two-cycle reset
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_data();
    t_periph();
    t_oc();
    t_hvi();
    stop_test();
  end

  // Watchdog well past the few hundred cycles the tests need
  initial begin
    #20000;
    failures++;
    stop_test();
  end
endmodule

`default_nettype wire

// ---- src/ppc_pkg.sv ----
// Constants, types and register map of the port pin control slice.
// Assumes a classic Wishbone master with 32-bit data on the bus side.
`default_nettype none

package ppc_pkg;
  // Register byte offsets
  localparam logic [7:0] PPC_OFS_DATA   = 8'h00;
  localparam logic [7:0] PPC_OFS_DIR    = 8'h04;
  localparam logic [7:0] PPC_OFS_LEVEL  = 8'h08;
  localparam logic [7:0] PPC_OFS_PULLEN = 8'h0c;
  localparam logic [7:0] PPC_OFS_PULLPO = 8'h10;
  localparam logic [7:0] PPC_OFS_WOR    = 8'h14;
  localparam logic [7:0] PPC_OFS_RDRV   = 8'h18;
  localparam logic [7:0] PPC_OFS_OCMON  = 8'h1c;
  localparam logic [7:0] PPC_OFS_OCIE   = 8'h20;
  localparam logic [7:0] PPC_OFS_OCFLAG = 8'h24;
  localparam logic [7:0] PPC_OFS_HVI    = 8'h28;
  // HIGH_VOLTAGE_INPUT control field positions
  localparam int PPC_HVI_ANALOG = 0;
  localparam int PPC_HVI_OVRD   = 1;
  localparam int PPC_HVI_DIE    = 2;
  localparam int PPC_HVI_IE     = 3;
  localparam int PPC_HVI_FLAG   = 4;
  localparam int PPC_HVI_LEVEL  = 5;
  // Reset values
  localparam logic [7:0] PPC_RST_BYTE = 8'h00;
  localparam logic [3:0] PPC_RST_HVI  = 4'h0;
  // Default pin sets
  localparam logic [7:0] PPC_IMPL_DEF = 8'hff;
  localparam logic [7:0] PPC_GND_DEF  = 8'h71;
  localparam int         PPC_SUP_DEF  = 2;

  // Peripheral requests per pin
  typedef struct packed {
    logic [7:0] tim_en;
    logic [7:0] tim_val;
    logic [7:0] sci_en;
    logic [7:0] sci_val;
    logic [7:0] spi_en;
    logic [7:0] spi_oe;
    logic [7:0] spi_val;
    logic [7:0] dac_en;
  } ppc_periph_t;

  // Pad controls per pin
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
    logic [7:0] pull_up;
    logic [7:0] full_drv;
  } ppc_pad_t;
endpackage

`default_nettype wire

// ---- src/ppc_port.sv ----
// One eight-pin port slice with over-current guard and a high-voltage input.
// Assumes pads, over-current comparators and HIGH_VOLTAGE_INPUT sit outside, asynchronous.
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ppc_port import ppc_pkg::*; #(
  parameter logic [7:0] IMPL_MASK = PPC_IMPL_DEF,
  parameter logic [7:0] GND_MASK  = PPC_GND_DEF,
  parameter int         SUP_PIN   = PPC_SUP_DEF
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Peripheral requests
  input  wire ppc_periph_t periph_in,
  // Pads and sensors
  input  wire logic [7:0]  pin_in,
  input  wire logic [7:0]  oc_detect_in,
  input  wire logic        stop_mode_in,
  output ppc_pad_t         pad_out,
  output logic      [7:0]  oc_monitor_on_out,
  output logic             oc_irq_out,
  // High-voltage input
  input  wire logic        hvi_in,
  output logic             hvi_buf_en_out,
  output logic             hvi_irq_out,
  output logic             hvi_wake_out
);

  localparam logic [7:0] SUP_MASK = 8'h01 << SUP_PIN;
  localparam logic [7:0] OC_MASK  = SUP_MASK | GND_MASK;

  // Shared three-stage sample with agreement filter
  function automatic logic [7:0] agree(input logic [7:0] s2,
                                       input logic [7:0] s3,
                                       input logic [7:0] cur);
    agree = (s2 & s3) | (cur & (s2 ^ s3));
  endfunction

  logic [7:0] data_q, dir_q, pullen_q, pullpo_q, wor_q, rdrv_q;
  logic [7:0] ocmon_q, ocie_q, ocflag_q;
  logic [3:0] hvi_q;
  logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q, lvl_q;
  logic [7:0] oc_s1_q, oc_s2_q, oc_s3_q, oc_q;
  logic [2:0] hvi_s_q;
  logic       hvi_lvl_q, hvi_prev_q, hvi_flag_q, ack_q;
  logic [31:0] rdat_q;
  logic       req, wr, wr_b0, hvi_edge;
  logic [7:0] oc_set, rd_port, drv_val, drv_oe, od, mon_on;

  // Bus request qualified once, single-cycle answer
  assign req   = wb_cyc_in & wb_stb_in & ~ack_q;
  assign wr    = req & wb_we_in;
  assign wr_b0 = wr & wb_sel_in[0];

  // Ack pulse one cycle after the request edge
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end
  assign wb_ack_out = ack_q;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      data_q <= PPC_RST_BYTE;
    end else if (wr_b0 && wb_adr_in == PPC_OFS_DATA) begin
      data_q <= wb_dat_in[7:0] & IMPL_MASK;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      dir_q    <= PPC_RST_BYTE;
      pullen_q <= PPC_RST_BYTE;
      pullpo_q <= PPC_RST_BYTE;
      wor_q    <= PPC_RST_BYTE;
      rdrv_q   <= PPC_RST_BYTE;
      ocmon_q  <= PPC_RST_BYTE;
      ocie_q   <= PPC_RST_BYTE;
      hvi_q    <= PPC_RST_HVI;
    end else if (wr_b0) begin
      case (wb_adr_in)
        PPC_OFS_DIR:    dir_q    <= wb_dat_in[7:0] & IMPL_MASK;
        PPC_OFS_PULLEN: pullen_q <= wb_dat_in[7:0] & IMPL_MASK;
        PPC_OFS_PULLPO: pullpo_q <= wb_dat_in[7:0] & IMPL_MASK;
        PPC_OFS_WOR:    wor_q    <= wb_dat_in[7:0] & IMPL_MASK;
        PPC_OFS_RDRV:   rdrv_q   <= wb_dat_in[7:0] & IMPL_MASK;
        PPC_OFS_OCMON:  ocmon_q  <= wb_dat_in[7:0] & OC_MASK;
        PPC_OFS_OCIE:   ocie_q   <= wb_dat_in[7:0] & OC_MASK;
        PPC_OFS_HVI:    hvi_q    <= wb_dat_in[3:0];
        default:        hvi_q    <= hvi_q;
      endcase
    end
  end

  // Pin inputs: three flops, a change counts once stages two and three agree
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1_q <= PPC_RST_BYTE;
      pin_s2_q <= PPC_RST_BYTE;
      pin_s3_q <= PPC_RST_BYTE;
      lvl_q    <= PPC_RST_BYTE;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      lvl_q    <= agree(pin_s2_q, pin_s3_q, lvl_q) & IMPL_MASK;
    end
  end

  // Comparator outputs sampled the same way
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      oc_s1_q <= PPC_RST_BYTE;
      oc_s2_q <= PPC_RST_BYTE;
      oc_s3_q <= PPC_RST_BYTE;
      oc_q    <= PPC_RST_BYTE;
    end else begin
      oc_s1_q <= oc_detect_in;
      oc_s2_q <= oc_s1_q;
      oc_s3_q <= oc_s2_q;
      oc_q    <= agree(oc_s2_q, oc_s3_q, oc_q);
    end
  end

  // output source priority: dac, timer, sci, spi, gpio
  always_comb begin
    drv_val = data_q;
    drv_oe  = dir_q;
    for (int i = 0; i < 8; i++) begin
      if (periph_in.dac_en[i]) begin
        drv_oe[i] = 1'b0;
      end else if (periph_in.tim_en[i]) begin
        drv_oe[i]  = 1'b1;
        drv_val[i] = periph_in.tim_val[i];
      end else if (periph_in.sci_en[i]) begin
        drv_oe[i]  = 1'b1;
        drv_val[i] = periph_in.sci_val[i];
      end else if (periph_in.spi_en[i]) begin
        drv_oe[i]  = periph_in.spi_oe[i];
        drv_val[i] = periph_in.spi_val[i];
      end
    end
  end

  // monitor live when enabled and out of stop, at either drive strength
  assign mon_on = ocmon_q & {8{~stop_mode_in}};
  assign oc_monitor_on_out = mon_on;
  assign od = wor_q & IMPL_MASK;

  // trip only while sourcing or sinking
  assign oc_set = oc_q & mon_on & ~rdrv_q & drv_oe & OC_MASK &
                  ((SUP_MASK & drv_val) | (GND_MASK & ~drv_val));

  // sticky flag, set beats a same-cycle clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ocflag_q <= PPC_RST_BYTE;
    end else if (wr_b0 && wb_adr_in == PPC_OFS_OCFLAG) begin
      ocflag_q <= (ocflag_q & ~wb_dat_in[7:0]) | oc_set;
    end else begin
      ocflag_q <= ocflag_q | oc_set;
    end
  end
  assign oc_irq_out = |(ocflag_q & ocie_q);

  // Pad drive; open-drain never drives high, so a wired bus is safe
  always_comb begin
    pad_out.full_drv = ~rdrv_q & IMPL_MASK;
    pad_out.out      = drv_val & IMPL_MASK;
    pad_out.oe       = drv_oe & ~(od & drv_val) & IMPL_MASK;
    pad_out.out = (pad_out.out & ~(ocflag_q & SUP_MASK)) |
                  (ocflag_q & GND_MASK);
    pad_out.oe  = pad_out.oe | (ocflag_q & SUP_MASK & drv_oe);
    pad_out.oe  = pad_out.oe & ~(ocflag_q & GND_MASK);
    // pull follows config unless a peripheral overrides
    pad_out.pull_en = pullen_q & ~drv_oe & IMPL_MASK;
    pad_out.pull_up = ~pullpo_q & IMPL_MASK;
    for (int i = 0; i < 8; i++) begin
      if (periph_in.dac_en[i] || periph_in.tim_en[i] ||
          periph_in.sci_en[i]) begin
        pad_out.pull_en[i] = 1'b0;
      end else if (periph_in.spi_en[i] && od[i] && pullpo_q[i]) begin
        pad_out.pull_en[i] = 1'b0;
      end
    end
  end

  // HIGH_VOLTAGE_INPUT buffer and level with agreement filter
  assign hvi_buf_en_out = hvi_q[PPC_HVI_DIE] &
                          (~hvi_q[PPC_HVI_ANALOG] | hvi_q[PPC_HVI_OVRD]);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hvi_s_q    <= 3'h0;
      hvi_lvl_q  <= 1'b0;
      hvi_prev_q <= 1'b0;
    end else begin
      hvi_s_q    <= {hvi_s_q[1:0], hvi_in};
      hvi_prev_q <= hvi_lvl_q;
      if (hvi_s_q[1] == hvi_s_q[2]) begin
        hvi_lvl_q <= hvi_s_q[2];
      end
    end
  end
  assign hvi_edge = hvi_lvl_q & ~hvi_prev_q;

  // run-mode interrupt only in digital mode; set beats clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hvi_flag_q <= 1'b0;
    end else if (hvi_edge && hvi_buf_en_out &&
                 !hvi_q[PPC_HVI_ANALOG]) begin
      hvi_flag_q <= 1'b1;
    end else if (wr_b0 && wb_adr_in == PPC_OFS_HVI &&
                 wb_dat_in[PPC_HVI_FLAG]) begin
      hvi_flag_q <= 1'b0;
    end
  end
  assign hvi_irq_out = hvi_flag_q & hvi_q[PPC_HVI_IE];
  // wake from stop in either mode
  assign hvi_wake_out = hvi_edge & stop_mode_in & hvi_q[PPC_HVI_IE];

  assign rd_port = ((data_q & dir_q) | (lvl_q & ~dir_q)) & IMPL_MASK;

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdat_q <= 32'h0;
    end else if (req) begin
      rdat_q <= 32'h0;
      case (wb_adr_in)
        PPC_OFS_DATA:   rdat_q[7:0] <= rd_port;
        PPC_OFS_DIR:    rdat_q[7:0] <= dir_q;
        PPC_OFS_LEVEL:  rdat_q[7:0] <= lvl_q;
        PPC_OFS_PULLEN: rdat_q[7:0] <= pullen_q;
        PPC_OFS_PULLPO: rdat_q[7:0] <= pullpo_q;
        PPC_OFS_WOR:    rdat_q[7:0] <= wor_q;
        PPC_OFS_RDRV:   rdat_q[7:0] <= rdrv_q;
        PPC_OFS_OCMON:  rdat_q[7:0] <= ocmon_q;
        PPC_OFS_OCIE:   rdat_q[7:0] <= ocie_q;
        PPC_OFS_OCFLAG: rdat_q[7:0] <= ocflag_q;
        PPC_OFS_HVI:    rdat_q[5:0] <= {hvi_lvl_q & hvi_buf_en_out,
                                        hvi_flag_q, hvi_q};
        default:        rdat_q <= 32'h0;
      endcase
    end
  end
  assign wb_dat_out = rdat_q;

  // Checks next to the logic they guard
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_rd_src;
    req && !wb_we_in && wb_adr_in == PPC_OFS_DATA |=>
      wb_ack_out && wb_dat_out[7:0] == $past(rd_port);
  endproperty
  a_rd_src: assert property (p_rd_src)
    else $error("port data read source wrong");

  // Upper bytes of every answer are zero as well, one byte per word
  property p_rd_zero;
    wb_ack_out |-> wb_dat_out[31:8] == 24'h0 &&
                   ((wb_dat_out[7:0] & ~IMPL_MASK) == 8'h00 ||
                    $past(wb_adr_in) != PPC_OFS_DATA);
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("unimplemented bit read nonzero");

  property p_gpio_drv;
    periph_in == '0 && ocflag_q == 8'h00 |->
      pad_out.out == data_q && pad_out.oe == (dir_q & ~(od & data_q));
  endproperty
  a_gpio_drv: assert property (p_gpio_drv)
    else $error("gpio drive mismatch");

  property p_lvl;
    pin_s2_q == pin_s3_q |=> lvl_q == ($past(pin_s3_q) & IMPL_MASK);
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("input level not following pins");

  property p_tim;
    periph_in.tim_en[0] && !periph_in.dac_en[0] && !ocflag_q[0] |->
      pad_out.oe[0] == ~(od[0] & periph_in.tim_val[0]) &&
      !pad_out.pull_en[0];
  endproperty
  a_tim: assert property (p_tim)
    else $error("timer pin not forced output");

  property p_dac;
    periph_in.dac_en[1] |-> !pad_out.oe[1] && !pad_out.pull_en[1];
  endproperty
  a_dac: assert property (p_dac)
    else $error("dac pin still driven");

  property p_oc_set;
    oc_set != 8'h00 |=> (ocflag_q & $past(oc_set)) == $past(oc_set)
      ##0 oc_irq_out == |(ocflag_q & ocie_q);
  endproperty
  a_oc_set: assert property (p_oc_set)
    else $error("over-current flag not set");

  property p_force;
    ocflag_q[SUP_PIN] |-> !pad_out.out[SUP_PIN];
  endproperty
  a_force: assert property (p_force)
    else $error("supply pin not forced low");

  property p_gnd_force;
    (ocflag_q & GND_MASK) != 8'h00 |->
      (pad_out.oe & ocflag_q & GND_MASK) == 8'h00 &&
      (pad_out.out & ocflag_q & GND_MASK) == (ocflag_q & GND_MASK);
  endproperty
  a_gnd_force: assert property (p_gnd_force)
    else $error("ground pin still sinking");

  // Only a taken write of one to this bit may drop the flag
  property p_hold;
    ocflag_q[SUP_PIN] &&
      !(wr_b0 && wb_adr_in == PPC_OFS_OCFLAG && wb_dat_in[SUP_PIN]) |=>
      ocflag_q[SUP_PIN];
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag dropped without clear");

  property p_stop;
    stop_mode_in |-> oc_monitor_on_out == 8'h00 && oc_set == 8'h00;
  endproperty
  a_stop: assert property (p_stop)
    else $error("monitor active in stop");

  property p_mon_off;
    ((oc_set | oc_monitor_on_out) & ~ocmon_q) == 8'h00;
  endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("monitor live while disabled");

  property p_clr;
    wr_b0 && wb_adr_in == PPC_OFS_OCFLAG && oc_set == 8'h00 |=>
      ocflag_q == ($past(ocflag_q) & ~$past(wb_dat_in[7:0]));
  endproperty
  a_clr: assert property (p_clr)
    else $error("write-one clear wrong");

  property p_hvi_buf;
    hvi_q[PPC_HVI_ANALOG] && !hvi_q[PPC_HVI_OVRD] |-> !hvi_buf_en_out;
  endproperty
  a_hvi_buf: assert property (p_hvi_buf)
    else $error("hvi buffer on in analog mode");

  c_oc_trip: cover property (oc_set != 8'h00 ##1 oc_irq_out);
  c_rd_port: cover property (p_rd_src);
  c_hvi_irq: cover property (hvi_edge ##1 hvi_irq_out);
  c_oc_clear: cover property (ocflag_q != 8'h00 ##1 ocflag_q == 8'h00);

endmodule

`default_nettype wire
